// *** rtl/srebt_pkg.sv ***
package srebt_pkg;

	// Register bus geometry
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;

	// Byte offsets of the registers
	localparam logic [7:0]  OFF_ENABLE   = 8'h44;
	localparam logic [7:0]  OFF_STATUS   = 8'h4c;

	// Value of the enable register after the main supply reset
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

	// Bits 28:3 store; 31:29 and 2:0 read zero
	localparam logic [31:0] WRITABLE_MASK = 32'h1fff_fff8;

	// Blocks that are reset or kept on sleep: 25:10, 8:5, 3
	localparam logic [31:0] COVERED_MASK  = 32'h03ff_fde8;

	// Bit that commands the first serial flash port to sleep
	localparam int          FLASH0_SLEEP_BIT = 9;

	// Sleep command sequence of the first serial flash port
	typedef enum {
		SREBT_FREE,
		SREBT_PENDING,
		SREBT_ASLEEP
	} srebt_flash_state_t;

endpackage

// *** rtl/srebt_gate_if.sv ***
`timescale 1ns/1ns
interface srebt_gate_if;
	import srebt_pkg::*;

	logic [DATA_W-1:0] enable;
	logic [DATA_W-1:0] asleep;
	logic [DATA_W-1:0] block_reset;

	modport ctrl (output enable, output asleep, input block_reset);
	modport gate (input enable, input asleep, output block_reset);
endinterface

// *** rtl/srebt_sleep_gate.sv ***
`timescale 1ns/1ns
module srebt_sleep_gate #(
	parameter logic [31:0] MASK = srebt_pkg::COVERED_MASK
) (
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   srst,
	// Enables in, sleep resets out
	srebt_gate_if.gate  gif
);
	import srebt_pkg::*;

	logic [DATA_W-1:0] was_asleep;
	logic [DATA_W-1:0] entry;
	logic [DATA_W-1:0] entry_keep;
	logic [DATA_W-1:0] entry_reset;

	// Sleep entry and the choice taken at that moment
	assign entry       = gif.asleep & ~was_asleep & MASK;
	assign entry_keep  = entry & ~gif.enable;
	assign entry_reset = entry & gif.enable;

	// Previous sleep level, for entry detection
	always_ff @(posedge clk) begin
		if (srst) begin
			was_asleep <= '0;
		end else begin
			was_asleep <= gif.asleep;
		end
	end

	// Enable is sampled at entry and held until wake, so a late write cannot
	// reset a block in the middle of its sleep
	always_ff @(posedge clk) begin
		if (srst) begin
			gif.block_reset <= '0;
		end else begin
			gif.block_reset <= gif.asleep & MASK & ((was_asleep & gif.block_reset) | entry_reset); // RULE1 RULE2
		end
	end

	AST_KEEP_ON_SLEEP: assert property (@(posedge clk) disable iff (srst) // RULE1
		##1 ((gif.block_reset & $past(entry_keep)) == '0))
		else $error("block with clear enable was reset on sleep");

	AST_RESET_ON_SLEEP: assert property (@(posedge clk) disable iff (srst) // RULE2
		##1 (($past(entry_reset) & ~gif.block_reset) == '0))
		else $error("block with set enable was not reset on sleep");

	AST_RESET_ONLY_ASLEEP: assert property (@(posedge clk) disable iff (srst) // RULE2
		##1 ((gif.block_reset & ~$past(gif.asleep)) == '0))
		else $error("sleep reset seen on an awake block");

	COV_RESET_ENTRY: cover property (@(posedge clk) disable iff (srst) entry_reset != '0);
	COV_KEEP_ENTRY: cover property (@(posedge clk) disable iff (srst) entry_keep != '0);

endmodule

// *** rtl/srebt_top.sv ***
// What this block does
// [RULE1] Clear enable bit: block keeps state asleep
// [RULE2] Set enable bit: block reset entering sleep
// [RULE3] Bit 9 clear: flash port zero clocks free
// [RULE4] Bit 9 set: flash port zero sleeps when able
// [RULE5] Firmware: reset-asleep block may refuse writes
// [RULE6] Reset clears; reserved read zero; vendor bits store
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module srebt_top (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             srst,
	// Register port
	input  wire logic [srebt_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic [srebt_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [srebt_pkg::DATA_W-1:0]     reg_rdata,
	// Sleep levels in, sleep resets out, one bit per block
	input  wire logic [srebt_pkg::DATA_W-1:0]     block_asleep,
	output logic      [srebt_pkg::DATA_W-1:0]     block_sleep_reset,
	// First serial flash port sleep handshake
	input  wire logic                             serial_flash_port_zero_idle,
	output logic                                  serial_flash_port_zero_sleep
);
	import srebt_pkg::*;

	logic [DATA_W-1:0]   sleep_reset_enable_second;
	srebt_flash_state_t  flash_state;
	srebt_flash_state_t  next_flash_state;
	logic                sleep_bit;
	logic                hit_enable;
	logic                hit_status;
	logic [DATA_W-1:0]   status_word;

	srebt_gate_if gif ();

	// Address decode
	assign hit_enable = (reg_addr == OFF_ENABLE);
	assign hit_status = (reg_addr == OFF_STATUS);
	assign sleep_bit  = sleep_reset_enable_second[FLASH0_SLEEP_BIT];

	// Enable register: main supply reset clears, reserved bits never store
	always_ff @(posedge clk) begin
		if (srst) begin
			sleep_reset_enable_second <= ENABLE_RESET; // RULE6
		end else if (reg_wr && hit_enable) begin
			sleep_reset_enable_second <= reg_wdata & WRITABLE_MASK; // RULE6
		end
	end

	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd && hit_enable) begin
			reg_rdata <= sleep_reset_enable_second; // RULE6
		end else if (reg_rd && hit_status) begin
			reg_rdata <= status_word;
		end else begin
			reg_rdata <= '0;
		end
	end

	// Status: blocks held in sleep reset, and the flash port asleep at bit 9
	always_comb begin
		status_word = block_sleep_reset;
		status_word[FLASH0_SLEEP_BIT] = serial_flash_port_zero_sleep;
	end

	// Per-block sleep reset gating; vendor bits and bit 9 are left out of the mask
	assign gif.enable = sleep_reset_enable_second;
	assign gif.asleep = block_asleep;
	assign block_sleep_reset = gif.block_reset;

	srebt_sleep_gate #(
		.MASK (COVERED_MASK)
	) u_gate (
		.clk  (clk),
		.srst (srst),
		.gif  (gif)
	);

	// Flash port sleep sequence: wait for idle, then hold it asleep
	always_comb begin
		next_flash_state = flash_state;
		unique case (flash_state)
			SREBT_FREE: begin
				if (sleep_bit && serial_flash_port_zero_idle) begin
					next_flash_state = SREBT_ASLEEP; // RULE4
				end else if (sleep_bit) begin
					next_flash_state = SREBT_PENDING;
				end
			end
			SREBT_PENDING: begin
				if (!sleep_bit) begin
					next_flash_state = SREBT_FREE; // RULE3
				end else if (serial_flash_port_zero_idle) begin
					next_flash_state = SREBT_ASLEEP; // RULE4
				end
			end
			SREBT_ASLEEP: begin
				if (!sleep_bit) begin
					next_flash_state = SREBT_FREE; // RULE3
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			flash_state <= SREBT_FREE;
		end else begin
			flash_state <= next_flash_state;
		end
	end

	// Sleep command flop, follows the next state so it lines up with it
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_flash_port_zero_sleep <= 1'b0;
		end else begin
			serial_flash_port_zero_sleep <= (next_flash_state == SREBT_ASLEEP); // RULE3 RULE4
		end
	end

	AST_FLASH_FREE: assert property (@(posedge clk) disable iff (srst) // RULE3
		!sleep_bit |=> !serial_flash_port_zero_sleep)
		else $error("flash port held asleep with bit 9 clear");

	AST_FLASH_SLEEP: assert property (@(posedge clk) disable iff (srst) // RULE4
		(sleep_bit && serial_flash_port_zero_idle) |=> serial_flash_port_zero_sleep)
		else $error("flash port not put to sleep when idle");

	AST_FLASH_WAIT: assert property (@(posedge clk) disable iff (srst) // RULE4
		(!serial_flash_port_zero_sleep && !serial_flash_port_zero_idle) |=> !serial_flash_port_zero_sleep)
		else $error("flash port put to sleep while busy");

	AST_FLASH_HOLD: assert property (@(posedge clk) disable iff (srst) // RULE4
		(serial_flash_port_zero_sleep && sleep_bit) |=> serial_flash_port_zero_sleep)
		else $error("flash port left sleep while commanded");

	AST_WRITE_STORE: assert property (@(posedge clk) disable iff (srst) // RULE6
		(reg_wr && hit_enable) |=> (sleep_reset_enable_second == ($past(reg_wdata) & WRITABLE_MASK)))
		else $error("enable register did not store the write");

	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (srst) // RULE6
		(reg_rd && hit_enable) |=> ((reg_rdata & ~WRITABLE_MASK) == '0))
		else $error("reserved enable bits read nonzero");

	AST_READ_ECHO: assert property (@(posedge clk) disable iff (srst) // RULE6
		(reg_wr && hit_enable) ##1 (reg_rd && hit_enable && !reg_wr)
		|=> (reg_rdata == ($past(reg_wdata, 2) & WRITABLE_MASK)))
		else $error("read back differs from written value");

	AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (srst)
		(reg_rd && !hit_enable && !hit_status) |=> (reg_rdata == '0))
		else $error("unmapped read returned nonzero");

	COV_FLASH_PENDING: cover property (@(posedge clk) disable iff (srst)
		flash_state == SREBT_PENDING ##1 flash_state == SREBT_ASLEEP);
	COV_FLASH_RELEASE: cover property (@(posedge clk) disable iff (srst)
		serial_flash_port_zero_sleep ##1 !serial_flash_port_zero_sleep);
	COV_WRITE_READ: cover property (@(posedge clk) disable iff (srst)
		(reg_wr && hit_enable) ##1 (reg_rd && hit_enable));

endmodule

// *** test/srebt_top_tb.sv ***
`timescale 1ns/1ns
module srebt_top_tb;
	import srebt_pkg::*;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] block_asleep = 32'h0;
	logic [31:0] block_sleep_reset;
	logic        flash_idle = 1'b0;
	logic        flash_sleep;
	int          err_count = 0;
	int          n_checks = 0;
	logic [31:0] rv;

	// Device under test
	srebt_top DUT (
		.clk                          (clk),
		.srst                         (srst),
		.reg_addr                     (reg_addr),
		.reg_wdata                    (reg_wdata),
		.reg_wr                       (reg_wr),
		.reg_rd                       (reg_rd),
		.reg_rdata                    (reg_rdata),
		.block_asleep                 (block_asleep),
		.block_sleep_reset            (block_sleep_reset),
		.serial_flash_port_zero_idle  (flash_idle),
		.serial_flash_port_zero_sleep (flash_sleep)
	);

	// 25 MHz clock
	always #20 clk = ~clk;

	// Closing report
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe, may follow a write with no gap; data taken at the edge closing the next cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask

	// Bounded wait for an output value; sel picks the flash sleep line
	task automatic poll(input string what, input bit sel, input logic [31:0] exp);
		logic [31:0] got;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			got = sel ? {31'h0, flash_sleep} : block_sleep_reset;
			if (got === exp) break;
		end
		check(what, exp, got);
		if (got !== exp) end_sim();
	endtask

	// Reset values, masks, read-only and unmapped places
	task automatic test_regs();
		rd(OFF_ENABLE, rv); check("enable reset", ENABLE_RESET, rv);
		check("sleep reset idle", 32'h0, block_sleep_reset);
		wr(OFF_ENABLE, 32'hffff_ffff);
		rd(OFF_ENABLE, rv); check("enable mask", WRITABLE_MASK, rv);
		wr(OFF_STATUS, 32'hffff_ffff);
		wr(8'h40, 32'h0);
		rd(OFF_ENABLE, rv); check("enable kept", WRITABLE_MASK, rv);
		rd(OFF_STATUS, rv); check("status", 32'h0, rv);
		rd(8'h40, rv); check("unmapped", 32'h0, rv);
		$display("test_regs done");
	endtask

	// Reset or keep on sleep entry, for both polarities of every writable bit
	task automatic test_sleep();
		logic [31:0] en;
		for (int k = 0; k < 2; k++) begin
			en = k ? (~32'h0155_8028 & WRITABLE_MASK) : 32'h0155_8028;
			wr(OFF_ENABLE, en);
			block_asleep <= 32'hffff_ffff;
			poll("sleep reset", 1'b0, en & COVERED_MASK);
			wr(OFF_ENABLE, ~en & WRITABLE_MASK);
			repeat (4) @(posedge clk);
			check("held", en & COVERED_MASK, block_sleep_reset);
			rd(OFF_STATUS, rv); check("status", en & COVERED_MASK, rv);
			block_asleep <= 32'h0;
			poll("wake", 1'b0, 32'h0);
		end
		$display("test_sleep done");
	endtask

	// Flash port zero sleep command waits for idle, stays until cleared
	task automatic test_flash();
		flash_idle <= 1'b0;
		wr(OFF_ENABLE, 32'h0000_0200);
		repeat (4) @(posedge clk);
		check("flash pending", 32'h0, {31'h0, flash_sleep});
		flash_idle <= 1'b1;
		poll("flash asleep", 1'b1, 32'h1);
		flash_idle <= 1'b0;
		repeat (4) @(posedge clk);
		check("flash held", 32'h1, {31'h0, flash_sleep});
		wr(OFF_ENABLE, 32'h0);
		poll("flash free", 1'b1, 32'h0);
		$display("test_flash done");
	endtask

	// Mid-run reset clears the register, the sleep resets and the flash command
	task automatic test_reset();
		wr(OFF_ENABLE, WRITABLE_MASK);
		block_asleep <= 32'hffff_ffff;
		flash_idle <= 1'b1;
		repeat (2) @(posedge clk);
		check("pre-reset sleep reset", COVERED_MASK, block_sleep_reset);
		check("pre-reset flash", 32'h1, {31'h0, flash_sleep});
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_ENABLE, rv); check("enable after reset", ENABLE_RESET, rv);
		check("sleep reset after reset", 32'h0, block_sleep_reset);
		check("flash after reset", 32'h0, {31'h0, flash_sleep});
		block_asleep <= 32'h0;
		flash_idle <= 1'b0;
		$display("test_reset done");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		test_regs();
		test_sleep();
		test_flash();
		test_reset();
		end_sim();
	end
endmodule
